// ==== hdl/quad_port_ddr_burst4_sram_if.sv ====
// What this block does
// - Address and selects are taken only on input clock rising edges.
// - Read and write commands are accepted on alternating rising edges.
// - Write beats 1 and 3 with byte selects taken on true clock rise.
// - Write beats 2 and 4 with byte selects taken on comp clock rise.
// - Only byte lanes whose select is active for that beat are written.
// - A write burst spans two cycles and all four beats are stored.
// - Read beats 1 and 3 leave on the third and fourth true rises.
// - Read beats 2 and 4 leave on the third and fourth comp rises.
// - A read burst spans two cycles delivering four beats.
// - Every transfer is exactly four beats; length is fixed.
// - Read and write bursts run concurrently with no turnaround.
// - Echo clocks change together with the read data beats.
// - Word is 36 bits by 2M or 18 bits by 4M.
// - Read valid flag is high with valid data, aligned to echo clocks.
// - Echo clocks toggle always, even with the data outputs idle.
// - DLL off input low selects reduced read latency, up to 167 MHz.
// - Address is ignored on edges with neither select active.
`timescale 1ns/1ps
module quad_port_ddr_burst4_sram_if #(
    parameter bit WIDE_WORD = 1'b1,
    parameter int DATA_W    = WIDE_WORD ? sram_port_pkg::X36_DATA_W
                                        : sram_port_pkg::X18_DATA_W,
    parameter int ADDR_W    = WIDE_WORD ? sram_port_pkg::X36_ADDR_W
                                        : sram_port_pkg::X18_ADDR_W,
    parameter int LANES     = DATA_W / sram_port_pkg::LANE_W
) (
    input  wire logic              clock,
    input  wire logic              rst_n,
    input  wire logic              input_clock_true,
    input  wire logic              input_clock_comp,
    input  wire logic              read_select_n,
    input  wire logic              write_select_n,
    input  wire logic [ADDR_W-1:0] sync_addr_in,
    input  wire logic [DATA_W-1:0] write_data,
    input  wire logic [LANES-1:0]  byte_write_select_n,
    input  wire logic              dll_off_n,
    output logic      [DATA_W-1:0] read_data,
    output logic                   read_data_oe,
    output logic                   read_valid_flag,
    output logic                   echo_clock_true,
    output logic                   echo_clock_comp
);
    import sram_port_pkg::*;

    localparam int IDX_W = ADDR_W + BEAT_W;

    logic              kt_s1_q, kt_s2_q, kt_prev_q;
    logic              kc_s1_q, kc_s2_q, kc_prev_q;
    logic              rd_s1_q, rd_s2_q;
    logic              wr_s1_q, wr_s2_q;
    logic              doff_s1_q, doff_s2_q;
    logic [ADDR_W-1:0] addr_s1_q, addr_s2_q;
    logic [DATA_W-1:0] data_s1_q, data_s2_q;
    logic [LANES-1:0]  bw_s1_q, bw_s2_q;

    logic              kt_rise, kc_rise;
    logic              rd_cmd, wr_cmd;
    logic              rd_prev_q, wr_prev_q;

    logic [RD_LAT_MAX:1] rd_v_q;
    logic [ADDR_W-1:0]   rd_a_q [1:RD_LAT_MAX];
    logic                rd_start;
    logic [ADDR_W-1:0]   rd_start_addr;
    rd_state_e           rd_state_q;
    logic [ADDR_W-1:0]   out_addr_q;
    logic                rd_emit;
    logic [IDX_W-1:0]    rd_index;
    logic [DATA_W-1:0]   rd_word;

    wr_state_e         wr_state_q;
    logic [ADDR_W-1:0] wr_addr_q, pend_addr_q;
    logic              pend_q;
    logic              wr_en;
    logic [BEAT_W-1:0] wr_beat;

    // Every pin passes two flip-flops before any logic reads it.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            kt_s1_q   <= PIN_LOW;
            kt_s2_q   <= PIN_LOW;
            kc_s1_q   <= PIN_LOW;
            kc_s2_q   <= PIN_LOW;
            rd_s1_q   <= SEL_INACTIVE;
            rd_s2_q   <= SEL_INACTIVE;
            wr_s1_q   <= SEL_INACTIVE;
            wr_s2_q   <= SEL_INACTIVE;
            doff_s1_q <= SEL_INACTIVE;
            doff_s2_q <= SEL_INACTIVE;
            addr_s1_q <= '0;
            addr_s2_q <= '0;
            data_s1_q <= '0;
            data_s2_q <= '0;
            bw_s1_q   <= '1;
            bw_s2_q   <= '1;
        end else begin
            kt_s1_q   <= input_clock_true;
            kt_s2_q   <= kt_s1_q;
            kc_s1_q   <= input_clock_comp;
            kc_s2_q   <= kc_s1_q;
            rd_s1_q   <= read_select_n;
            rd_s2_q   <= rd_s1_q;
            wr_s1_q   <= write_select_n;
            wr_s2_q   <= wr_s1_q;
            doff_s1_q <= dll_off_n;
            doff_s2_q <= doff_s1_q;
            addr_s1_q <= sync_addr_in;
            addr_s2_q <= addr_s1_q;
            data_s1_q <= write_data;
            data_s2_q <= data_s1_q;
            bw_s1_q   <= byte_write_select_n;
            bw_s2_q   <= bw_s1_q;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            kt_prev_q <= PIN_LOW;
            kc_prev_q <= PIN_LOW;
        end else begin
            kt_prev_q <= kt_s2_q;
            kc_prev_q <= kc_s2_q;
        end
    end

    assign kt_rise = kt_s2_q & ~kt_prev_q;
    assign kc_rise = kc_s2_q & ~kc_prev_q;

    // A command of one kind directly after its own kind is dropped, and
    // read wins when both selects are low on the same edge.
    assign rd_cmd = kt_rise & ~rd_s2_q & ~rd_prev_q;
    assign wr_cmd = kt_rise & ~wr_s2_q & ~wr_prev_q & ~rd_cmd;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rd_prev_q <= 1'b0;
            wr_prev_q <= 1'b0;
        end else if (kt_rise) begin
            rd_prev_q <= rd_cmd;
            wr_prev_q <= wr_cmd;
        end
    end

    // Read command pipeline, one stage per true clock rise.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rd_v_q <= '0;
            for (int i = 1; i <= RD_LAT_MAX; i++) begin
                rd_a_q[i] <= '0;
            end
        end else if (kt_rise) begin
            rd_v_q[1] <= rd_cmd;
            if (rd_cmd) begin
                rd_a_q[1] <= addr_s2_q;
            end
            for (int i = 2; i <= RD_LAT_MAX; i++) begin
                rd_v_q[i] <= rd_v_q[i-1];
                rd_a_q[i] <= rd_a_q[i-1];
            end
        end
    end

    // With the DLL off the burst starts one true rise sooner.
    assign rd_start = doff_s2_q ? rd_v_q[RD_LAT_DLL_ON]
                                : rd_v_q[RD_LAT_DLL_OFF];
    assign rd_start_addr = doff_s2_q ? rd_a_q[RD_LAT_DLL_ON]
                                     : rd_a_q[RD_LAT_DLL_OFF];

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rd_state_q <= RD_IDLE;
            out_addr_q <= '0;
        end else if (kt_rise) begin
            case (rd_state_q)
                RD_B2: begin
                    rd_state_q <= RD_B3;
                end
                default: begin
                    if (rd_start) begin
                        rd_state_q <= RD_B1;
                        out_addr_q <= rd_start_addr;
                    end else begin
                        rd_state_q <= RD_IDLE;
                    end
                end
            endcase
        end else if (kc_rise) begin
            case (rd_state_q)
                RD_B1: begin
                    rd_state_q <= RD_B2;
                end
                RD_B3: begin
                    rd_state_q <= RD_B4;
                end
                default: begin
                    rd_state_q <= rd_state_q;
                end
            endcase
        end
    end

    // Selects which stored word leaves with the coming clock edge.
    always_comb begin
        rd_emit  = 1'b0;
        rd_index = {out_addr_q, BEAT_1};
        if (kt_rise) begin
            if (rd_state_q == RD_B2) begin
                rd_emit  = 1'b1;
                rd_index = {out_addr_q, BEAT_3};
            end else if (rd_start) begin
                rd_emit  = 1'b1;
                rd_index = {rd_start_addr, BEAT_1};
            end
        end else if (kc_rise) begin
            if (rd_state_q == RD_B1) begin
                rd_emit  = 1'b1;
                rd_index = {out_addr_q, BEAT_2};
            end else if (rd_state_q == RD_B3) begin
                rd_emit  = 1'b1;
                rd_index = {out_addr_q, BEAT_4};
            end
        end
    end

    // A read issued after a write never meets that write's beat in the
    // same cycle, so the array alone keeps read data coherent.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            read_data       <= '0;
            read_valid_flag <= 1'b0;
        end else if (kt_rise | kc_rise) begin
            read_valid_flag <= rd_emit;
            if (rd_emit) begin
                read_data <= rd_word;
            end
        end
    end

    assign read_data_oe = read_valid_flag;

    // Echo clocks follow the input clocks on the same edge as the data.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            echo_clock_true <= PIN_LOW;
            echo_clock_comp <= PIN_LOW;
        end else begin
            echo_clock_true <= kt_s2_q;
            echo_clock_comp <= kc_s2_q;
        end
    end

    // Write sequencer: state names the next beat expected.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wr_state_q  <= WR_IDLE;
            wr_addr_q   <= '0;
            pend_addr_q <= '0;
            pend_q      <= 1'b0;
        end else if (kt_rise) begin
            case (wr_state_q)
                WR_IDLE: begin
                    if (wr_cmd) begin
                        wr_state_q <= WR_B1;
                        wr_addr_q  <= addr_s2_q;
                    end
                end
                WR_B1: begin
                    wr_state_q <= WR_B2;
                end
                WR_B3: begin
                    wr_state_q <= WR_B4;
                    if (wr_cmd) begin
                        pend_q      <= 1'b1;
                        pend_addr_q <= addr_s2_q;
                    end
                end
                default: begin
                    wr_state_q <= wr_state_q;
                end
            endcase
        end else if (kc_rise) begin
            case (wr_state_q)
                WR_B2: begin
                    wr_state_q <= WR_B3;
                end
                WR_B4: begin
                    pend_q <= 1'b0;
                    if (pend_q) begin
                        wr_state_q <= WR_B1;
                        wr_addr_q  <= pend_addr_q;
                    end else begin
                        wr_state_q <= WR_IDLE;
                    end
                end
                default: begin
                    wr_state_q <= wr_state_q;
                end
            endcase
        end
    end

    // Write beats go to the array while reads proceed independently.
    always_comb begin
        wr_en   = 1'b0;
        wr_beat = BEAT_1;
        if (kt_rise && wr_state_q == WR_B1) begin
            wr_en   = 1'b1;
            wr_beat = BEAT_1;
        end else if (kt_rise && wr_state_q == WR_B3) begin
            wr_en   = 1'b1;
            wr_beat = BEAT_3;
        end else if (kc_rise && wr_state_q == WR_B2) begin
            wr_en   = 1'b1;
            wr_beat = BEAT_2;
        end else if (kc_rise && wr_state_q == WR_B4) begin
            wr_en   = 1'b1;
            wr_beat = BEAT_4;
        end
    end

    sram_burst_array #(
        .IDX_W  (IDX_W),
        .DATA_W (DATA_W),
        .LANES  (LANES)
    ) u_array (
        .clock      (clock),
        .wr_en      (wr_en),
        .wr_index   ({wr_addr_q, wr_beat}),
        .wr_data    (data_s2_q),
        .wr_lane_en (~bw_s2_q),
        .rd_index   (rd_index),
        .rd_data    (rd_word)
    );

endmodule

// ==== hdl/sram_port_pkg.sv ====
package sram_port_pkg;

    localparam int          LANE_W         = 9;
    localparam int          X36_DATA_W     = 36;
    localparam int          X18_DATA_W     = 18;
    localparam int          X36_ADDR_W     = 19;
    localparam int          X18_ADDR_W     = 20;
    localparam int          BEAT_W         = 2;

    localparam logic [1:0]  BEAT_1         = 2'h0;
    localparam logic [1:0]  BEAT_2         = 2'h1;
    localparam logic [1:0]  BEAT_3         = 2'h2;
    localparam logic [1:0]  BEAT_4         = 2'h3;

    localparam int          RD_LAT_DLL_ON  = 2;
    localparam int          RD_LAT_DLL_OFF = 1;
    localparam int          RD_LAT_MAX     = 2;

    localparam logic        SEL_INACTIVE   = 1'h1;
    localparam logic        PIN_LOW        = 1'h0;

    typedef enum logic [4:0] {
        RD_IDLE = 5'h01,
        RD_B1   = 5'h02,
        RD_B2   = 5'h04,
        RD_B3   = 5'h08,
        RD_B4   = 5'h10
    } rd_state_e;

    typedef enum logic [4:0] {
        WR_IDLE = 5'h01,
        WR_B1   = 5'h02,
        WR_B2   = 5'h04,
        WR_B3   = 5'h08,
        WR_B4   = 5'h10
    } wr_state_e;

endpackage

// ==== hdl/sram_burst_array.sv ====
`timescale 1ns/1ps
module sram_burst_array #(
    parameter int IDX_W  = 21,
    parameter int DATA_W = 36,
    parameter int LANES  = 4
) (
    input  wire logic              clock,
    input  wire logic              wr_en,
    input  wire logic [IDX_W-1:0]  wr_index,
    input  wire logic [DATA_W-1:0] wr_data,
    input  wire logic [LANES-1:0]  wr_lane_en,
    input  wire logic [IDX_W-1:0]  rd_index,
    output logic      [DATA_W-1:0] rd_data
);
    import sram_port_pkg::*;

    logic [DATA_W-1:0] mem [0:(2**IDX_W)-1];

    // Lanes without an enable keep their stored contents.
    always_ff @(posedge clock) begin
        if (wr_en) begin
            for (int l = 0; l < LANES; l++) begin
                if (wr_lane_en[l]) begin
                    mem[wr_index][l*LANE_W +: LANE_W] <=
                        wr_data[l*LANE_W +: LANE_W];
                end
            end
        end
    end

    // The read port sees the array before this cycle's write lands.
    assign rd_data = mem[rd_index];

endmodule

// ==== tb/quad_port_monitor.sv ====
`timescale 1ns/1ps
module quad_port_monitor #(
    parameter int DATA_W = 36,
    parameter int ADDR_W = 19,
    parameter int LANES  = 4
) (
    input wire logic              clock,
    input wire logic              rst_n,
    input wire logic              input_clock_true,
    input wire logic              input_clock_comp,
    input wire logic              read_select_n,
    input wire logic              write_select_n,
    input wire logic [ADDR_W-1:0] sync_addr_in,
    input wire logic [DATA_W-1:0] write_data,
    input wire logic [LANES-1:0]  byte_write_select_n,
    input wire logic              dll_off_n,
    input wire logic [DATA_W-1:0] read_data,
    input wire logic              read_data_oe,
    input wire logic              read_valid_flag,
    input wire logic              echo_clock_true,
    input wire logic              echo_clock_comp
);
    logic [2:0] up_q;
    logic [7:0] idle_q;
    default clocking @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    // Keeps $past from reaching back across a reset.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) up_q <= 3'h0;
        else if (up_q != 3'h7) up_q <= up_q + 3'h1;
    end
    // Cycles since the read select was last seen low.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) idle_q <= 8'hFF;
        else if (!read_select_n) idle_q <= 8'h00;
        else if (idle_q != 8'hFF) idle_q <= idle_q + 8'h01;
    end
    chk_echo_true: assert property (
        up_q == 3'h7 |-> echo_clock_true == $past(input_clock_true, 3))
        else $error("echo true clock off");
    chk_echo_comp: assert property (
        up_q == 3'h7 |-> echo_clock_comp == $past(input_clock_comp, 3))
        else $error("echo comp clock off");
    chk_oe_valid: assert property (read_data_oe == read_valid_flag)
        else $error("enable and valid differ");
    chk_valid_rise: assert property (
        $rose(read_valid_flag) |-> $rose(echo_clock_true))
        else $error("valid rose off an echo rise");
    chk_data_beat: assert property (
        up_q == 3'h7 && $changed(read_data)
        |-> $rose(echo_clock_true) || $rose(echo_clock_comp))
        else $error("read data moved off an echo edge");
    chk_burst_half: assert property (
        $rose(read_valid_flag)
        |-> ##[1:30] ($rose(echo_clock_comp) && read_valid_flag))
        else $error("second beat missing");
    chk_read_cause: assert property (
        $rose(read_valid_flag) |-> idle_q <= 8'h5A)
        else $error("valid without a read");
    chk_idle_quiet: assert property (
        idle_q == 8'hFF |-> !read_valid_flag)
        else $error("valid outlasts the burst");
    cover property ($rose(read_valid_flag));
    cover property (!dll_off_n && $rose(read_valid_flag));
    cover property ($fell(write_select_n));
endmodule
bind quad_port_ddr_burst4_sram_if quad_port_monitor #(
    .DATA_W(DATA_W), .ADDR_W(ADDR_W), .LANES(LANES)) i_mon (
    .clock(clock),
    .rst_n(rst_n),
    .input_clock_true(input_clock_true),
    .input_clock_comp(input_clock_comp),
    .read_select_n(read_select_n),
    .write_select_n(write_select_n),
    .sync_addr_in(sync_addr_in),
    .write_data(write_data),
    .byte_write_select_n(byte_write_select_n),
    .dll_off_n(dll_off_n),
    .read_data(read_data),
    .read_data_oe(read_data_oe),
    .read_valid_flag(read_valid_flag),
    .echo_clock_true(echo_clock_true),
    .echo_clock_comp(echo_clock_comp)
);

// ==== tb/sram_ctrl_model.sv ====
`timescale 1ns/1ps
module sram_ctrl_model #(
    parameter int DATA_W = 36,
    parameter int ADDR_W = 19,
    parameter int LANES  = 4
) (
    input  wire logic              clock,
    output logic                   k_true,
    output logic                   k_comp,
    output logic                   rd_n,
    output logic                   wr_n,
    output logic      [ADDR_W-1:0] addr,
    output logic      [DATA_W-1:0] wdata,
    output logic      [LANES-1:0]  bw_n
);
    int                h_n = 1;
    int                nr;
    logic [1:0]        cmd[256] = '{default: 2'h0};
    logic [ADDR_W-1:0] cadr[256];
    logic              dv[512] = '{default: 1'b0};
    logic [DATA_W-1:0] dd[512];
    logic [LANES-1:0]  db[512];
    task automatic cmd_at(input int r, input logic [1:0] c,
                          input logic [ADDR_W-1:0] a);
        cmd[r] = c;
        cadr[r] = a;
    endtask
    task automatic beat_at(input int h, input logic [DATA_W-1:0] d,
                           input logic [LANES-1:0] b);
        dv[h] = 1'b1;
        dd[h] = d;
        db[h] = b;
    endtask
    initial begin
        k_true = 1'b0;
        // Both start low so that time zero shows no rise on either clock.
        k_comp = 1'b0;
        rd_n = 1'b1;
        wr_n = 1'b1;
        addr = '0;
        wdata = '0;
        bw_n = '1;
        #7.3;
        k_true = 1'b1;
        forever begin
            #80;
            k_true = ~k_true;
            k_comp = ~k_comp;
        end
    end
    // Inputs move 40 ns before the edge that takes them; idle lines flip.
    always @(posedge k_true or posedge k_comp) begin
        h_n = h_n + 1;
        #40;
        @(negedge clock);
        nr = (h_n + 1) / 2;
        if (h_n % 2 == 1) begin
            rd_n = !cmd[nr][1];
            wr_n = !cmd[nr][0];
            addr = (cmd[nr] != 2'h0) ? cadr[nr] : ~addr;
        end
        wdata = dv[h_n + 1] ? dd[h_n + 1] : ~wdata;
        bw_n = dv[h_n + 1] ? db[h_n + 1] : ~bw_n;
    end
endmodule

// ==== tb/test_quad_port_ddr_burst4_sram_if.sv ====
`timescale 1ns/1ps
module test_quad_port_ddr_burst4_sram_if;
    import sram_port_pkg::*;
    localparam int DW = X36_DATA_W;
    localparam int AW = X36_ADDR_W;
    localparam int LN = DW / LANE_W;
    typedef logic [DW-1:0] burst_t[4];
    typedef logic [LN-1:0] mask_t[4];
    localparam mask_t         FULL = '{4'h0, 4'h0, 4'h0, 4'h0};
    localparam logic [AW-1:0] A    = 19'h00012;
    localparam logic [AW-1:0] B    = 19'h7FFFF;
    logic          clock;
    logic          rst_n;
    logic          dll_off_n;
    logic          k_t;
    logic          k_c;
    logic          rd_n;
    logic          wr_n;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic [LN-1:0] bw_n;
    logic [DW-1:0] rdata;
    logic [X18_DATA_W-1:0] rdata18;
    logic          oe;
    logic          vld;
    logic          eq_t;
    logic          eq_c;
    logic          et_q;
    logic          ec_q;
    logic [DW-1:0] cap_d[$];
    logic [X18_DATA_W-1:0] cap18[$];
    int            cap_r[$];
    int            n_fail = 0;
    int            samples_checked = 0;
    int            cyc = 0;
    burst_t        a_exp;
    sram_ctrl_model #(.DATA_W(DW), .ADDR_W(AW), .LANES(LN)) ctl (
        .clock(clock), .k_true(k_t), .k_comp(k_c), .rd_n(rd_n),
        .wr_n(wr_n), .addr(addr), .wdata(wdata), .bw_n(bw_n));
    quad_port_ddr_burst4_sram_if #(.WIDE_WORD(1'b1)) i_dut (
        .clock(clock), .rst_n(rst_n), .input_clock_true(k_t),
        .input_clock_comp(k_c), .read_select_n(rd_n),
        .write_select_n(wr_n), .sync_addr_in(addr), .write_data(wdata),
        .byte_write_select_n(bw_n), .dll_off_n(dll_off_n),
        .read_data(rdata), .read_data_oe(oe), .read_valid_flag(vld),
        .echo_clock_true(eq_t), .echo_clock_comp(eq_c));
    // The narrow word sees the same traffic on its low two lanes.
    quad_port_ddr_burst4_sram_if #(.WIDE_WORD(1'b0)) i_dut_x18 (
        .clock(clock), .rst_n(rst_n), .input_clock_true(k_t),
        .input_clock_comp(k_c), .read_select_n(rd_n),
        .write_select_n(wr_n), .sync_addr_in({1'b1, addr}),
        .write_data(wdata[X18_DATA_W-1:0]),
        .byte_write_select_n(bw_n[1:0]), .dll_off_n(dll_off_n),
        .read_data(rdata18), .read_data_oe(), .read_valid_flag(),
        .echo_clock_true(), .echo_clock_comp());
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    // Each beat is logged with the link rise it belongs to.
    always @(negedge clock) begin
        if (vld === 1'b1 && ((eq_t && !et_q) || (eq_c && !ec_q))) begin
            cap_d.push_back(rdata);
            cap18.push_back(rdata18);
            cap_r.push_back(ctl.h_n / 2);
        end
        et_q <= eq_t;
        ec_q <= eq_c;
    end
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            n_fail++;
            final_report();
        end
    end
    task automatic final_report();
        $display("checks %0d failures %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic check(input string what, input logic [63:0] seen,
                         input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s exp %h seen %h", what, exp, seen);
        end
    endtask
    function automatic burst_t words(input int s);
        for (int i = 0; i < 4; i++) words[i] = {s[3:0], i[3:0], 28'h5A3C96E};
    endfunction
    task automatic burst(input int k, input int r0, input burst_t e);
        for (int i = 0; i < 4; i++) begin
            check("read beat", cap_d[k + i], e[i]);
            check("x18 beat", cap18[k + i], e[i][X18_DATA_W-1:0]);
            check("beat rise", cap_r[k + i], r0 + i / 2);
        end
    endtask
    task automatic wr(input int r, input logic [AW-1:0] a, input int s,
                      input mask_t b);
        burst_t d;
        d = words(s);
        ctl.cmd_at(r, 2'h1, a);
        for (int i = 0; i < 4; i++) ctl.beat_at(2 * r + 2 + i, d[i], b[i]);
    endtask
    task automatic start(output int r);
        cap_d.delete();
        cap_r.delete();
        cap18.delete();
        r = ctl.h_n / 2 + 2;
    endtask
    task automatic upto(input int r);
        while (ctl.h_n / 2 < r) @(negedge clock);
    endtask
    task automatic t_lanes();
        int     r;
        mask_t  m;
        burst_t n;
        m = '{4'hE, 4'h5, 4'hF, 4'h0};
        start(r);
        wr(r, A, 2, FULL);
        wr(r + 2, A, 3, m);
        ctl.cmd_at(r + 5, 2'h2, A);
        upto(r + 10);
        a_exp = words(2);
        n = words(3);
        for (int i = 0; i < 4; i++) begin
            for (int l = 0; l < LN; l++) begin
                if (!m[i][l])
                    a_exp[i][LANE_W*l+:LANE_W] = n[i][LANE_W*l+:LANE_W];
            end
        end
        check("beats", cap_d.size(), 4);
        burst(0, r + 7, a_exp);
        $display("test lanes done");
    endtask
    task automatic t_conc();
        int r;
        start(r);
        wr(r, B, 4, FULL);
        ctl.cmd_at(r + 1, 2'h2, B);
        wr(r + 2, B, 5, FULL);
        ctl.cmd_at(r + 3, 2'h2, B);
        upto(r + 8);
        check("beats", cap_d.size(), 8);
        burst(0, r + 3, words(4));
        burst(4, r + 5, words(5));
        $display("test concurrent done");
    endtask
    task automatic t_refused();
        int r;
        start(r);
        ctl.cmd_at(r, 2'h2, A);
        ctl.cmd_at(r + 1, 2'h2, 19'h00000);
        wr(r + 2, B, 6, FULL);
        ctl.cmd_at(r + 2, 2'h3, B);
        ctl.cmd_at(r + 4, 2'h2, B);
        upto(r + 9);
        check("beats", cap_d.size(), 12);
        burst(0, r + 2, a_exp);
        burst(4, r + 4, words(5));
        burst(8, r + 6, words(5));
        $display("test refused done");
    endtask
    task automatic t_dll();
        int r;
        dll_off_n = 1'b0;
        start(r);
        ctl.cmd_at(r, 2'h2, B);
        upto(r + 5);
        check("beats", cap_d.size(), 4);
        burst(0, r + 1, words(5));
        dll_off_n = 1'b1;
        $display("test dll off done");
    endtask
    initial begin
        rst_n = 1'b0;
        dll_off_n = 1'b1;
        repeat (5) @(negedge clock);
        rst_n = 1'b1;
        t_lanes();
        t_conc();
        t_refused();
        t_dll();
        final_report();
    end
endmodule
